// >>> hw/svc_pkg.sv
// shared constants and types of the servo command-source and mode selector
// assumes one 125 MHz core clock; all parameter values arrive as plain ports
package svc_pkg;
  localparam int POS_W = 32;
  localparam int SPD_W = 16;
  localparam int TRQ_W = 16;
  localparam int ANA_W = 16;
  localparam int GEAR_W = 16;
  localparam logic [3:0] CM_POS = 4'h0;
  localparam logic [3:0] CM_SPD = 4'h1;
  localparam logic [3:0] CM_TRIAL = 4'h2;
  localparam logic [3:0] CM_JOG = 4'h3;
  localparam logic [3:0] CM_TRQ = 4'h6;
  localparam logic [1:0] FORCE_ON = 2'h2;
  localparam logic [7:0] FN_SERVO_ON = 8'h01;
  localparam logic [1:0] SEG_ONCE = 2'h0;
  localparam logic [1:0] SEG_LOOP = 2'h1;
  localparam logic [1:0] SEG_INDEX = 2'h2;
  localparam logic [1:0] SEG_STEP = 2'h3;
  localparam logic [1:0] PT_PULSE_DIR = 2'h0;
  localparam logic [1:0] PT_CW_CCW = 2'h1;
  localparam logic [1:0] PT_QUAD = 2'h2;
  localparam int CAL_SHIFT = 8;
  localparam int NPIN = 14;
  localparam int PIN_TRIG = 0;
  localparam int PIN_PS0 = 1;
  localparam int PIN_SS0 = 4;
  localparam int PIN_TS0 = 7;
  localparam int PIN_UP = 9;
  localparam int PIN_DN = 10;
  localparam int PIN_SON = 11;
  localparam int PIN_PA = 12;
  localparam int PIN_PB = 13;
  typedef enum logic [3:0] {
    MODE_NONE, MODE_POS_INT, MODE_POS_PULSE, MODE_SPD_INT, MODE_SPD_ANA,
    MODE_TRQ_INT, MODE_TRQ_ANA, MODE_TRIAL, MODE_JOG
  } mode_type;
  typedef struct packed {
    logic [POS_W-1:0] target;
    logic [SPD_W-1:0] speed;
  } seg_type;
  typedef struct packed {
    logic start;
    logic absolute;
    logic [2:0] index;
    seg_type seg;
  } move_type;
endpackage

// >>> hw/seg_table.sv
// eight stored position segments (target pair plus speed)
// assumes writes come from parameter logic on the same clock; read data is registered
`timescale 1ns/1ps
module seg_table import svc_pkg::*; #(
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire seg_type wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output seg_type rdData_ff
);
  seg_type mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    rdData_ff <= mem[rdAddr];
  end
endmodule

// >>> hw/servo_mode_select.sv
// command-source and mode selection of the servo drive
// assumes pins are asynchronous, parameters and analog samples come from core_clk logic
// Overview of operation
// - mode 2 gives key-driven signed speed trial
// - mode 3 gives jog at jog speed
// - up CCW, down CW, release holds zero
// - enable by servo-on input or forced parameter
// - mode 0 source 1 runs stored positions
// - eight stored target pairs, calculation mode selectable
// - run mode 0 runs segments once, returns home
// - run mode 0 trigger needs positioning complete
// - run mode 1 loops while trigger active
// - run mode 2 falling trigger starts move
// - select code picks pair and speed, completes
// - run mode 3 home, previous, next stepping
// - mode 0 source 0 follows external pulses
// - pulses scaled by numerator over denominator
// - mode 1 source 1 uses preset speeds
// - speed select code k picks preset k+1
// - mode 1 source 0 uses analog speed
// - speed offset capture once running, then done
// - mode 6 source 1 uses preset torques
// - torque select code k picks preset k+1
// - mode 6 source 0 uses analog torque
// - torque offset capture once running, then done
`timescale 1ns/1ps
module servo_mode_select import svc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] ctrlMode,
  input wire logic posSource,
  input wire logic speedSource,
  input wire logic torqueSource,
  input wire logic [1:0] forceEnable,
  input wire logic [7:0] input1Function,
  input wire logic servoOnPin,
  input wire logic keyUp,
  input wire logic keyDown,
  input wire logic [SPD_W-1:0] jogSpeed,
  input wire logic [SPD_W-1:0] trialStep,
  input wire logic [1:0] segMode,
  input wire logic [3:0] segCount,
  input wire logic posAbsolute,
  input wire logic segWrEn,
  input wire logic [2:0] segWrIdx,
  input wire seg_type segWrData,
  input wire logic segmentTrigger,
  input wire logic positionSelect0,
  input wire logic positionSelect1,
  input wire logic positionSelect2,
  input wire logic moveDone,
  input wire logic pulseA,
  input wire logic pulseB,
  input wire logic [1:0] pulseType,
  input wire logic [GEAR_W-1:0] gearNum,
  input wire logic [GEAR_W-1:0] gearDen,
  input wire logic [7:0][SPD_W-1:0] presetSpeed,
  input wire logic speedSelect0,
  input wire logic speedSelect1,
  input wire logic speedSelect2,
  input wire logic [3:0][TRQ_W-1:0] presetTorque,
  input wire logic torqueSelect0,
  input wire logic torqueSelect1,
  input wire logic [ANA_W-1:0] analogIn,
  input wire logic analogStrobe,
  input wire logic calSpeedReq,
  input wire logic calTorqueReq,
  output mode_type mode_ff,
  output logic servoOn_ff,
  output logic zeroLock_ff,
  output logic [SPD_W-1:0] speedCmd_ff,
  output logic [TRQ_W-1:0] torqueCmd_ff,
  output move_type move_ff,
  output logic posComplete_ff,
  output logic [POS_W-1:0] pulsePos_ff,
  output logic [ANA_W-1:0] speedOffset_ff,
  output logic [ANA_W-1:0] torqueOffset_ff,
  output logic calDone_ff
);
  typedef enum logic [1:0] {SQ_IDLE, SQ_FETCH, SQ_GO, SQ_RUN} seq_type;

  function automatic logic [2:0] code3(input logic b2, input logic b1, input logic b0);
    code3 = {b2, b1, b0};
  endfunction

  logic [NPIN-1:0] pinRaw, meta_ff, sync_ff, prev_ff, rise, fall;
  assign pinRaw = {pulseB, pulseA, servoOnPin, keyDown, keyUp, torqueSelect1, torqueSelect0,
                   speedSelect2, speedSelect1, speedSelect0,
                   positionSelect2, positionSelect1, positionSelect0, segmentTrigger};

  // meta_ff is read only by sync_ff
  for (genvar i = 0; i < NPIN; i++) begin : gSync
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
        prev_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= pinRaw[i];
        sync_ff[i] <= meta_ff[i];
        prev_ff[i] <= sync_ff[i];
      end
    end
  end

  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
  mode_type nxt_mode;
  always_comb begin
    case (ctrlMode)
      CM_POS: nxt_mode = posSource ? MODE_POS_INT : MODE_POS_PULSE;
      CM_SPD: nxt_mode = speedSource ? MODE_SPD_INT : MODE_SPD_ANA;
      CM_TRQ: nxt_mode = torqueSource ? MODE_TRQ_INT : MODE_TRQ_ANA;
      CM_TRIAL: nxt_mode = MODE_TRIAL;
      CM_JOG: nxt_mode = MODE_JOG;
      default: nxt_mode = MODE_NONE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_NONE;
      servoOn_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      servoOn_ff <= (input1Function == FN_SERVO_ON && sync_ff[PIN_SON]) || forceEnable == FORCE_ON;
    end
  end
  // trial speed steps once per key press, so a held key does not run away
  logic [SPD_W-1:0] trialSpeed_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trialSpeed_ff <= '0;
    end else if (mode_ff != MODE_TRIAL) begin
      trialSpeed_ff <= '0;
    end else if (rise[PIN_UP]) begin
      trialSpeed_ff <= trialSpeed_ff + trialStep;
    end else if (rise[PIN_DN]) begin
      trialSpeed_ff <= trialSpeed_ff - trialStep;
    end
  end
  logic [SPD_W-1:0] nxt_speed;
  logic [TRQ_W-1:0] nxt_torque;
  always_comb begin
    nxt_speed = '0;
    nxt_torque = '0;
    case (mode_ff)
      MODE_TRIAL: nxt_speed = trialSpeed_ff;
      MODE_JOG: begin
        if (sync_ff[PIN_UP]) begin
          nxt_speed = jogSpeed;
        end else if (sync_ff[PIN_DN]) begin
          nxt_speed = SPD_W'(-jogSpeed);
        end
      end
      MODE_SPD_INT: nxt_speed = presetSpeed[code3(sync_ff[PIN_SS0+2], sync_ff[PIN_SS0+1], sync_ff[PIN_SS0])];
      MODE_SPD_ANA: nxt_speed = analogIn - speedOffset_ff;
      MODE_TRQ_INT: nxt_torque = presetTorque[{sync_ff[PIN_TS0+1], sync_ff[PIN_TS0]}];
      MODE_TRQ_ANA: nxt_torque = analogIn - torqueOffset_ff;
      default: nxt_speed = '0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      speedCmd_ff <= '0;
      torqueCmd_ff <= '0;
      zeroLock_ff <= 1'b0;
    end else begin
      speedCmd_ff <= servoOn_ff ? nxt_speed : '0;
      torqueCmd_ff <= servoOn_ff ? nxt_torque : '0;
      zeroLock_ff <= mode_ff == MODE_JOG && !sync_ff[PIN_UP] && !sync_ff[PIN_DN];
    end
  end
  // stored segments
  seq_type seq_ff;
  logic [2:0] segIdx_ff, segLeft_ff, lastIdx;
  seg_type segData;
  logic posRun;
  assign lastIdx = (segCount == 4'h0) ? 3'h0 : (segCount > 4'h8) ? 3'h7 : 3'(segCount - 4'h1);
  assign posRun = mode_ff == MODE_POS_INT && servoOn_ff;
  seg_table #(.DEPTH(8)) i_seg_table (
    .core_clk(core_clk),
    .wrEn(segWrEn),
    .wrAddr(segWrIdx),
    .wrData(segWrData),
    .rdAddr(segIdx_ff),
    .rdData_ff(segData)
  );
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= SQ_IDLE;
      segIdx_ff <= '0;
      segLeft_ff <= '0;
      posComplete_ff <= 1'b1;
    end else if (!posRun) begin
      seq_ff <= SQ_IDLE;
      segLeft_ff <= '0;
      posComplete_ff <= 1'b1;
    end else begin
      case (seq_ff)
        SQ_IDLE: begin
          case (segMode)
            SEG_ONCE: begin
              if (rise[PIN_TRIG] && posComplete_ff) begin
                segIdx_ff <= '0;
                segLeft_ff <= lastIdx;
                seq_ff <= SQ_FETCH;
              end
            end
            SEG_LOOP: begin
              if (sync_ff[PIN_TRIG]) begin
                segIdx_ff <= '0;
                segLeft_ff <= lastIdx;
                seq_ff <= SQ_FETCH;
              end
            end
            SEG_INDEX: begin
              if (fall[PIN_TRIG]) begin
                segIdx_ff <= code3(sync_ff[PIN_PS0+2], sync_ff[PIN_PS0+1], sync_ff[PIN_PS0]);
                segLeft_ff <= '0;
                seq_ff <= SQ_FETCH;
              end
            end
            SEG_STEP: begin
              segLeft_ff <= '0;
              if (rise[PIN_PS0+2]) begin
                segIdx_ff <= '0;
                seq_ff <= SQ_FETCH;
              end else if (rise[PIN_PS0+1]) begin
                segIdx_ff <= (segIdx_ff == 3'h0) ? 3'h0 : segIdx_ff - 3'h1;
                seq_ff <= SQ_FETCH;
              end else if (rise[PIN_PS0]) begin
                segIdx_ff <= (segIdx_ff >= lastIdx) ? segIdx_ff : segIdx_ff + 3'h1;
                seq_ff <= SQ_FETCH;
              end
            end
            default: seq_ff <= SQ_IDLE;
          endcase
        end
        SQ_FETCH: seq_ff <= SQ_GO; // table read takes one cycle
        SQ_GO: begin
          posComplete_ff <= 1'b0;
          seq_ff <= SQ_RUN;
        end
        SQ_RUN: begin
          if (moveDone) begin
            if (segMode == SEG_LOOP && !sync_ff[PIN_TRIG]) begin
              seq_ff <= SQ_IDLE;
              posComplete_ff <= 1'b1;
            end else if ((segMode == SEG_ONCE || segMode == SEG_LOOP) && segLeft_ff != 3'h0) begin
              segIdx_ff <= segIdx_ff + 3'h1;
              segLeft_ff <= segLeft_ff - 3'h1;
              seq_ff <= SQ_FETCH;
            end else if (segMode == SEG_LOOP) begin
              segIdx_ff <= '0;
              segLeft_ff <= lastIdx;
              seq_ff <= SQ_FETCH;
            end else if (segMode == SEG_ONCE && segIdx_ff != 3'h0) begin
              segIdx_ff <= '0;
              seq_ff <= SQ_FETCH;
            end else begin
              seq_ff <= SQ_IDLE;
              posComplete_ff <= 1'b1;
            end
          end
        end
        default: seq_ff <= SQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_ff <= '0;
    end else begin
      move_ff.start <= posRun && seq_ff == SQ_GO;
      if (seq_ff == SQ_GO) begin
        move_ff.seg <= segData;
        move_ff.index <= segIdx_ff;
        move_ff.absolute <= posAbsolute;
      end
    end
  end
  // pulse input with electronic gear; input rate must stay below clock * den / num
  logic signed [GEAR_W+17:0] residue_ff;
  logic pUp, pDn;
  always_comb begin
    pUp = 1'b0;
    pDn = 1'b0;
    case (pulseType)
      PT_PULSE_DIR: begin
        pUp = rise[PIN_PA] && !sync_ff[PIN_PB];
        pDn = rise[PIN_PA] && sync_ff[PIN_PB];
      end
      PT_CW_CCW: begin
        pUp = rise[PIN_PA];
        pDn = rise[PIN_PB];
      end
      PT_QUAD: begin
        pUp = (prev_ff[PIN_PA] ^ sync_ff[PIN_PB]) && !(prev_ff[PIN_PB] ^ sync_ff[PIN_PA]);
        pDn = (prev_ff[PIN_PB] ^ sync_ff[PIN_PA]) && !(prev_ff[PIN_PA] ^ sync_ff[PIN_PB]);
      end
      default: pUp = 1'b0;
    endcase
  end
  logic signed [GEAR_W+17:0] numS, denS, nxt_residue;
  assign numS = {18'h00000, gearNum};
  assign denS = {18'h00000, (gearDen == '0) ? GEAR_W'(1) : gearDen};
  assign nxt_residue = residue_ff + (pUp ? numS : '0) - (pDn ? numS : '0);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      residue_ff <= '0;
      pulsePos_ff <= '0;
    end else if (mode_ff != MODE_POS_PULSE || !servoOn_ff) begin
      residue_ff <= '0;
    end else if (nxt_residue >= denS) begin
      residue_ff <= nxt_residue - denS;
      pulsePos_ff <= pulsePos_ff + 32'h00000001;
    end else if (nxt_residue <= -denS) begin
      residue_ff <= nxt_residue + denS;
      pulsePos_ff <= pulsePos_ff - 32'h00000001;
    end else begin
      residue_ff <= nxt_residue;
    end
  end
  // zero-drift capture averages 2**CAL_SHIFT analog samples
  logic calBusy_ff, calTorque_ff;
  logic [CAL_SHIFT:0] calCnt_ff;
  logic signed [ANA_W+CAL_SHIFT-1:0] calAcc_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      calBusy_ff <= 1'b0;
      calTorque_ff <= 1'b0;
      calCnt_ff <= '0;
      calAcc_ff <= '0;
      calDone_ff <= 1'b0;
      speedOffset_ff <= '0;
      torqueOffset_ff <= '0;
    end else begin
      calDone_ff <= 1'b0;
      if (!calBusy_ff) begin
        if (servoOn_ff && (calSpeedReq || calTorqueReq)) begin
          calBusy_ff <= 1'b1;
          calTorque_ff <= calTorqueReq && !calSpeedReq;
          calCnt_ff <= '0;
          calAcc_ff <= '0;
        end
      end else if (calCnt_ff[CAL_SHIFT]) begin
        calBusy_ff <= 1'b0;
        calDone_ff <= 1'b1;
        if (calTorque_ff) begin
          torqueOffset_ff <= calAcc_ff[ANA_W+CAL_SHIFT-1:CAL_SHIFT];
        end else begin
          speedOffset_ff <= calAcc_ff[ANA_W+CAL_SHIFT-1:CAL_SHIFT];
        end
      end else if (analogStrobe) begin
        calAcc_ff <= calAcc_ff + {{CAL_SHIFT{analogIn[ANA_W-1]}}, analogIn};
        calCnt_ff <= calCnt_ff + 1'b1;
      end
    end
  end
endmodule

// >>> testbench/servo_mode_select_properties.sv
// assertion checker bound onto the command-source and mode selector
// assumes one clock domain; sees the selector's ports only
`timescale 1ns/1ps
module servo_mode_select_checker import svc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] ctrlMode,
  input wire logic posSource,
  input wire logic speedSource,
  input wire logic torqueSource,
  input wire logic [1:0] forceEnable,
  input wire logic [7:0] input1Function,
  input wire logic [SPD_W-1:0] jogSpeed,
  input wire mode_type mode_ff,
  input wire logic servoOn_ff,
  input wire logic [SPD_W-1:0] speedCmd_ff,
  input wire logic [TRQ_W-1:0] torqueCmd_ff,
  input wire move_type move_ff,
  input wire logic posComplete_ff,
  input wire logic [ANA_W-1:0] speedOffset_ff,
  input wire logic [ANA_W-1:0] torqueOffset_ff,
  input wire logic calDone_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  function automatic mode_type expMode(logic [3:0] m, logic p, logic s, logic t);
    case (m)
      CM_POS: return p ? MODE_POS_INT : MODE_POS_PULSE;
      CM_SPD: return s ? MODE_SPD_INT : MODE_SPD_ANA;
      CM_TRQ: return t ? MODE_TRQ_INT : MODE_TRQ_ANA;
      CM_TRIAL: return MODE_TRIAL;
      CM_JOG: return MODE_JOG;
      default: return MODE_NONE;
    endcase
  endfunction
  property p_mode;
    1'b1 |=> mode_ff == expMode($past(ctrlMode), $past(posSource), $past(speedSource), $past(torqueSource));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not decoded");
  property p_force;
    forceEnable == FORCE_ON |=> servoOn_ff;
  endproperty
  a_force: assert property (p_force) else $error("forced enable ignored");
  property p_noen;
    forceEnable != FORCE_ON && input1Function != FN_SERVO_ON |=> !servoOn_ff;
  endproperty
  a_noen: assert property (p_noen) else $error("enabled without source");
  // one cycle of command latency, so judge only after a settled off span
  property p_off;
    !servoOn_ff [*4] |-> speedCmd_ff == '0 && torqueCmd_ff == '0;
  endproperty
  a_off: assert property (p_off) else $error("command while disabled");
  property p_jog;
    (mode_ff == MODE_JOG && servoOn_ff) [*3] |-> speedCmd_ff inside {'0, jogSpeed, SPD_W'(-jogSpeed)};
  endproperty
  a_jog: assert property (p_jog) else $error("jog speed wrong");
  property p_start;
    move_ff.start |-> !posComplete_ff ##1 !move_ff.start;
  endproperty
  a_start: assert property (p_start) else $error("start not a pulse");
  property p_fall;
    $fell(posComplete_ff) |-> move_ff.start;
  endproperty
  a_fall: assert property (p_fall) else $error("complete dropped alone");
  property p_cal;
    calDone_ff |=> !calDone_ff;
  endproperty
  a_cal: assert property (p_cal) else $error("done not a pulse");
  property p_offs;
    $changed(speedOffset_ff) || $changed(torqueOffset_ff) |-> calDone_ff;
  endproperty
  a_offs: assert property (p_offs) else $error("offset moved alone");
  c_jog: cover property (mode_ff == MODE_JOG && speedCmd_ff == jogSpeed);
  c_move: cover property (move_ff.start ##1 !posComplete_ff);
  c_cal: cover property (calDone_ff);
endmodule
bind servo_mode_select servo_mode_select_checker i_checker (.*);

// >>> testbench/motion_model.sv
// motion and analog source model on the far side of the selector
// assumes core_clk; answers each move start with a done pulse after DLY cycles
`timescale 1ns/1ps
module motion_model import svc_pkg::*; #(
  parameter int DLY = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire move_type move,
  input wire logic [ANA_W-1:0] level,
  output logic moveDone,
  output logic [ANA_W-1:0] analogIn,
  output logic analogStrobe
);
  int cnt;
  // done only ever follows a start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      moveDone <= 1'b0;
    end else begin
      moveDone <= cnt == 1;
      if (move.start) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // a fresh sample every cycle keeps offset sums exact
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analogStrobe <= 1'b0;
      analogIn <= '0;
    end else begin
      analogStrobe <= 1'b1;
      analogIn <= level;
    end
  end
endmodule

// >>> testbench/servo_mode_select_tb.sv
// self-checking bench for the command-source and mode selector
// assumes the motion model answers moves and feeds the analog input
`timescale 1ns/1ps
module servo_mode_select_tb import svc_pkg::*; ;
  localparam int DLY = 6;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ctrlMode = '0;
  logic posSource = 1'b0, speedSource = 1'b0, torqueSource = 1'b0;
  logic [1:0] forceEnable = '0, segMode = '0, pulseType = '0;
  logic [7:0] input1Function = '0;
  logic [SPD_W-1:0] jogSpeed = 16'h0123, trialStep = 16'h0010;
  logic [3:0] segCount = 4'h3;
  logic posAbsolute = 1'b1, segWrEn = 1'b0, calSpeedReq = 1'b0, calTorqueReq = 1'b0;
  logic [2:0] segWrIdx = '0;
  seg_type segWrData = '0;
  logic [NPIN-1:0] pins = '0;
  logic [GEAR_W-1:0] gearNum = 16'h0003, gearDen = 16'h0002;
  logic [7:0][SPD_W-1:0] presetSpeed;
  logic [3:0][TRQ_W-1:0] presetTorque;
  logic [ANA_W-1:0] level = 16'h0123;
  mode_type mode_ff;
  logic servoOn_ff, zeroLock_ff, posComplete_ff, calDone_ff, moveDone, analogStrobe;
  logic [SPD_W-1:0] speedCmd_ff;
  logic [TRQ_W-1:0] torqueCmd_ff;
  move_type move_ff;
  logic [POS_W-1:0] pulsePos_ff;
  logic [ANA_W-1:0] speedOffset_ff, torqueOffset_ff, analogIn;
  seg_type tbl [8];
  int errorCnt = 0, nTests = 0;
  always #4 core_clk = ~core_clk;
  servo_mode_select i_servo_mode_select (.*, .servoOnPin(pins[PIN_SON]), .keyUp(pins[PIN_UP]),
    .keyDown(pins[PIN_DN]), .segmentTrigger(pins[PIN_TRIG]), .positionSelect0(pins[PIN_PS0]),
    .positionSelect1(pins[PIN_PS0+1]), .positionSelect2(pins[PIN_PS0+2]), .pulseA(pins[PIN_PA]),
    .pulseB(pins[PIN_PB]), .speedSelect0(pins[PIN_SS0]), .speedSelect1(pins[PIN_SS0+1]),
    .speedSelect2(pins[PIN_SS0+2]), .torqueSelect0(pins[PIN_TS0]), .torqueSelect1(pins[PIN_TS0+1]));
  motion_model #(.DLY(DLY)) i_motion_model (.*, .move(move_ff));
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(int p);
    pins[p] = 1'b1;
    tick(2);
    pins[p] = 1'b0;
    tick(2);
  endtask
  task automatic waitStart(int k);
    tick(1);
    for (int i = 0; i < 60 && move_ff.start !== 1'b1; i++) tick(1);
    chk("start", 1'b1, move_ff.start);
    chk("index", k, move_ff.index);
    chk("seg", tbl[k], move_ff.seg);
    chk("absolute", posAbsolute, move_ff.absolute);
  endtask
  task automatic waitCal();
    for (int i = 0; i < 600 && calDone_ff !== 1'b1; i++) tick(1);
    chk("cal done", 1'b1, calDone_ff);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_basic();
    logic [3:0] cm [9] = '{CM_POS, CM_POS, CM_SPD, CM_SPD, CM_TRQ, CM_TRQ, CM_TRIAL, CM_JOG, 4'h5};
    mode_type em [9] = '{MODE_POS_INT, MODE_POS_PULSE, MODE_SPD_INT, MODE_SPD_ANA, MODE_TRQ_INT,
      MODE_TRQ_ANA, MODE_TRIAL, MODE_JOG, MODE_NONE};
    for (int i = 0; i < 9; i++) begin
      ctrlMode = cm[i];
      {posSource, speedSource, torqueSource} = {3{~i[0]}};
      tick(2);
      chk("mode", em[i], mode_ff);
    end
    pins[PIN_SON] = 1'b1;
    tick(6);
    chk("servo", 1'b0, servoOn_ff);
    input1Function = FN_SERVO_ON;
    tick(6);
    chk("servo", 1'b1, servoOn_ff);
    pins[PIN_SON] = 1'b0;
    tick(6);
    chk("servo", 1'b0, servoOn_ff);
    forceEnable = FORCE_ON;
    tick(2);
    chk("servo", 1'b1, servoOn_ff);
    $display("test modes and enable finished");
  endtask
  task automatic t_pulses();
    ctrlMode = CM_POS;
    posSource = 1'b0;
    pulseType = PT_PULSE_DIR;
    tick(4);
    repeat (4) pulse(PIN_PA);
    tick(12);
    chk("count", 4 * gearNum / gearDen, pulsePos_ff);
    pulseType = PT_CW_CCW;
    tick(2);
    repeat (2) pulse(PIN_PB);
    tick(12);
    chk("count", 2 * gearNum / gearDen, pulsePos_ff);
    pulseType = PT_QUAD;
    tick(2);
    // one full gray cycle with B leading counts four steps up
    for (int i = 1; i <= 4; i++) begin
      {pins[PIN_PA], pins[PIN_PB]} = 2'(i) ^ (2'(i) >> 1);
      tick(4);
    end
    tick(8);
    chk("count", 6 * gearNum / gearDen, pulsePos_ff);
    $display("test pulses finished");
  endtask
  task automatic t_keys();
    ctrlMode = CM_JOG;
    pins[PIN_UP] = 1'b1;
    tick(8);
    chk("jog", jogSpeed, speedCmd_ff);
    chk("lock", 1'b0, zeroLock_ff);
    pins[PIN_DN] = 1'b1;
    pins[PIN_UP] = 1'b0;
    tick(8);
    chk("jog", SPD_W'(-jogSpeed), speedCmd_ff);
    pins[PIN_DN] = 1'b0;
    tick(8);
    chk("jog", 1'b0, speedCmd_ff);
    chk("lock", 1'b1, zeroLock_ff);
    ctrlMode = CM_TRIAL;
    tick(4);
    repeat (2) pulse(PIN_UP);
    tick(6);
    chk("trial", 2 * trialStep, speedCmd_ff);
    repeat (3) pulse(PIN_DN);
    tick(6);
    chk("trial", SPD_W'(-trialStep), speedCmd_ff);
    $display("test keys finished");
  endtask
  task automatic t_presets();
    ctrlMode = CM_SPD;
    speedSource = 1'b1;
    for (int k = 0; k < 8; k++) begin
      pins[PIN_SS0+:3] = 3'(k);
      tick(8);
      chk("speed", presetSpeed[k], speedCmd_ff);
    end
    ctrlMode = CM_TRQ;
    torqueSource = 1'b1;
    for (int k = 0; k < 4; k++) begin
      pins[PIN_TS0+:2] = 2'(k);
      tick(8);
      chk("torque", presetTorque[k], torqueCmd_ff);
    end
    pins = '0;
    $display("test presets finished");
  endtask
  task automatic t_analog();
    ctrlMode = CM_SPD;
    speedSource = 1'b0;
    tick(4);
    calSpeedReq = 1'b1;
    tick(1);
    calSpeedReq = 1'b0;
    waitCal();
    chk("speed offset", level, speedOffset_ff);
    level = 16'h0200;
    tick(6);
    chk("speed", level - 16'h0123, speedCmd_ff);
    ctrlMode = CM_TRQ;
    torqueSource = 1'b0;
    tick(4);
    calTorqueReq = 1'b1;
    tick(1);
    calTorqueReq = 1'b0;
    waitCal();
    chk("torque offset", level, torqueOffset_ff);
    tick(6);
    chk("torque", 1'b0, torqueCmd_ff);
    $display("test analog finished");
  endtask
  task automatic t_segments();
    int sp [4] = '{0, 0, 1, 2};
    int se [4] = '{1, 2, 1, 0};
    ctrlMode = CM_POS;
    posSource = 1'b1;
    segMode = SEG_INDEX;
    for (int k = 0; k < 8; k++) begin
      pins[PIN_PS0+:3] = 3'(k);
      posAbsolute = k[0];
      tick(6);
      pins[PIN_TRIG] = 1'b1;
      tick(6);
      pins[PIN_TRIG] = 1'b0;
      waitStart(k);
      tick(DLY + 4);
      chk("complete", 1'b1, posComplete_ff);
    end
    pins = '0;
    segMode = SEG_ONCE;
    tick(6);
    pulse(PIN_TRIG);
    waitStart(0);
    pulse(PIN_TRIG);
    waitStart(1);
    waitStart(2);
    waitStart(0);
    tick(DLY + 4);
    chk("complete", 1'b1, posComplete_ff);
    tick(20);
    chk("complete", 1'b1, posComplete_ff);
    segMode = SEG_LOOP;
    segCount = 4'h2;
    pins[PIN_TRIG] = 1'b1;
    waitStart(0);
    waitStart(1);
    waitStart(0);
    pins[PIN_TRIG] = 1'b0;
    tick(DLY + 20);
    chk("complete", 1'b1, posComplete_ff);
    segMode = SEG_STEP;
    segCount = 4'h3;
    for (int i = 0; i < 4; i++) begin
      pulse(PIN_PS0 + sp[i]);
      waitStart(se[i]);
      tick(DLY + 4);
    end
    $display("test segments finished");
  endtask
  initial begin
    for (int k = 0; k < 8; k++) begin
      presetSpeed[k] = 16'h0200 + 16'(k);
      tbl[k] = '{target: 32'h0001_0000 * (k + 1), speed: 16'h0040 + 16'(k)};
      if (k < 4) presetTorque[k] = 16'h0300 + 16'(k);
    end
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tick(4);
    for (int k = 0; k < 8; k++) begin
      segWrEn = 1'b1;
      segWrIdx = 3'(k);
      segWrData = tbl[k];
      tick(1);
    end
    segWrEn = 1'b0;
    t_basic();
    t_pulses();
    t_keys();
    t_presets();
    t_analog();
    t_segments();
    conclude();
  end
  initial begin
    #100us;
    errorCnt++;
    $display("[FAIL] watchdog expected end seen hang");
    conclude();
  end
endmodule
